// File: pms_pkg.sv
// constants, register map and state encoding of the power mode sequencer
// assumes a 32-bit classic wishbone register bus and one 10 MHz clock
package pms_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_CLK_CTRL  = 8'h00;  // system_clock_control
   localparam logic [7:0] ADR_STBY_CTRL = 8'h04;  // standby_control
   localparam logic [7:0] ADR_STATUS    = 8'h08;  // sequencer state

   // system_clock_control fields
   localparam int CLK_SEL_BIT  = 0;  // clock_select_bit, 1 = main clock
   localparam int CLK_MON_BIT  = 1;  // clock_monitor_flag, read only
   localparam logic CLK_SEL_RST = 1'b1;

   // standby_control fields
   localparam int STBY_STOP_BIT  = 7;
   localparam int STBY_SLEEP_BIT = 6;
   localparam int STBY_HIZ_BIT   = 5;
   localparam int STBY_SWRST_BIT = 4;
   localparam int STBY_WATCH_BIT = 3;
   localparam logic STBY_HIZ_RST = 1'b0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int SW_RST_INSTR    = 4;   // instruction cycles of soft reset
   localparam int CLK_PER_INSTR   = 1;
   localparam int SW_RST_CYCLES   = SW_RST_INSTR * CLK_PER_INSTR;
   localparam int SW_RST_CW       = 3;

   // ----------------------------------------------------------------
   // operating states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RESET,
      ST_MAIN_RUN,
      ST_SUB_RUN,
      ST_SLEEP,
      ST_STOP,
      ST_WATCH
   } pms_state_t;

   localparam int STATE_W = 3;

endpackage

// File: pms_sync_if.sv
// bundle carrying raw pin levels to the synchroniser and the synced copy back
// assumes the pins are asynchronous to mclk
`timescale 1ns/1ps
interface pms_sync_if #(parameter int N = 2);
   logic [N-1:0] raw;
   logic [N-1:0] sync;
   modport stage (input raw, output sync);
   modport user  (output raw, input sync);
endinterface

// File: pms_sync_stage.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes the synced levels are read only after the second flop
`timescale 1ns/1ps
module pms_sync_stage #(
   parameter int N = 2
) (
   // clock and reset
   input  wire logic   mclk,
   input  wire logic   rst,
   // pin bundle
   pms_sync_if.stage   pins
);
   logic [N-1:0] meta_q;
   logic [N-1:0] sync_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pins.raw;
         sync_q <= meta_q;
      end
   end

   assign pins.sync = sync_q;
endmodule // pms_sync_stage

// File: pms_sequencer.sv
// operating-state sequencer: main run, sub run, sleep, stop, watch, reset
// assumes oscillator wait timers outside that pulse on expiry, a 10 MHz
// mclk and a classic wishbone master for the control registers
//
// Notes on behaviour
// - power-on: main run after wait and release
// - main run: ext, soft, watchdog reset
// - clock select written 0: main to sub
// - clock select 1: main after wait, monitored
// - boot into sub only after sub wait
// - sleep request from either run state
// - sleep left on interrupt or ext reset
// - stop request from either run state
// - stop left by ext irq after wait
// - watch only from sub run, select 0
// - watch left on ext/watch irq, reset
// - standby: no soft or watchdog reset
// - single clock: no sub run, watch
// - watch request in main clock ignored
// - standby request refused on pending irq
// - stop wins over other requests
`timescale 1ns/1ps
module pms_sequencer
   import pms_pkg::*;
#(
   parameter bit HAS_POR    = 1'b1,
   parameter bit DUAL_CLOCK = 1'b1,
   parameter bit BOOT_SUB   = 1'b0
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // pins
   input  wire logic        extResetN,
   input  wire logic        extIrq,
   // on-chip events
   input  wire logic        irqPending,
   input  wire logic        watchIrq,
   input  wire logic        wdtReset,
   input  wire logic        mainWaitDone,
   input  wire logic        subWaitDone,
   // state outputs
   output logic             sysReset,
   output logic             cpuRun,
   output logic             sysClkSub,
   output logic             mainOscEn,
   output logic             subOscEn,
   output logic             pinHiZ,
   output logic [2:0]       stateCode
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   pms_sync_if #(.N(2)) pinBus ();

   assign pinBus.raw = {extIrq, extResetN};

   pms_sync_stage #(.N(2)) uSync (
      .mclk (mclk),
      .rst  (rst),
      .pins (pinBus)
   );

   wire extRst   = ~pinBus.sync[0];  // reset held until pin seen high
   wire extIrqS  = pinBus.sync[1];

   // ----------------------------------------------------------------
   // state and registers
   // ----------------------------------------------------------------
   pms_state_t             state_q, state_d;
   logic                   clkSel_q;
   logic                   hiZ_q;
   logic                   onSub_q, onSub_d;
   logic                   wake_q;
   logic                   mainRdy_q;
   logic                   subRdy_q;
   logic [SW_RST_CW-1:0]   swCnt_q;
   logic                   ack_q;
   logic [31:0]            rdData_q;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire busReq    = wb_cyc_i & wb_stb_i;
   wire busWrite  = busReq & wb_we_i & ack_q & wb_sel_i[0];
   wire selClk    = (wb_adr_i == ADR_CLK_CTRL);
   wire selStby   = (wb_adr_i == ADR_STBY_CTRL);
   wire selStat   = (wb_adr_i == ADR_STATUS);
   wire wrClk     = busWrite & selClk;
   wire wrStby    = busWrite & selStby;

   wire reqStop   = wrStby & wb_dat_i[STBY_STOP_BIT];
   wire reqSleep  = wrStby & wb_dat_i[STBY_SLEEP_BIT];
   wire reqWatch  = wrStby & wb_dat_i[STBY_WATCH_BIT];
   wire reqSwRst  = wrStby & wb_dat_i[STBY_SWRST_BIT];
   wire selNew    = wb_dat_i[CLK_SEL_BIT] | ~DUAL_CLOCK;

   // ----------------------------------------------------------------
   // transition conditions
   // ----------------------------------------------------------------
   wire inRun      = (state_q == ST_MAIN_RUN) | (state_q == ST_SUB_RUN);
   wire swRst      = (swCnt_q != '0);
   wire runReset   = extRst | (inRun & (swRst | wdtReset));
   wire stbyOk     = inRun & ~irqPending;
   wire goStop     = stbyOk & reqStop;
   wire goSleep    = stbyOk & reqSleep & ~reqStop;
   wire watchOk    = DUAL_CLOCK & (state_q == ST_SUB_RUN) & ~clkSel_q;
   wire goWatch    = stbyOk & watchOk & reqWatch
                   & ~reqStop & ~reqSleep;
   wire bootWait   = (DUAL_CLOCK & BOOT_SUB) ? subRdy_q : mainRdy_q;
   wire leaveReset = ~extRst & ~swRst & (~HAS_POR | bootWait);
   wire resumeRdy  = onSub_q ? subRdy_q : mainRdy_q;
   wire resumeSt   = onSub_q;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RESET: begin
            if (leaveReset) begin
               state_d = (DUAL_CLOCK & BOOT_SUB) ? ST_SUB_RUN
                                                 : ST_MAIN_RUN;
            end
         end
         ST_MAIN_RUN: begin
            if (runReset)            state_d = ST_RESET;
            else if (goStop)         state_d = ST_STOP;
            else if (goSleep)        state_d = ST_SLEEP;
            else if (wrClk & ~selNew) state_d = ST_SUB_RUN;
         end
         ST_SUB_RUN: begin
            if (runReset)            state_d = ST_RESET;
            else if (goStop)         state_d = ST_STOP;
            else if (goSleep)        state_d = ST_SLEEP;
            else if (goWatch)        state_d = ST_WATCH;
            else if (clkSel_q & mainRdy_q) state_d = ST_MAIN_RUN;
         end
         ST_SLEEP: begin
            if (extRst)              state_d = ST_RESET;
            else if (irqPending) begin
               state_d = resumeSt ? ST_SUB_RUN : ST_MAIN_RUN;
            end
         end
         ST_STOP: begin
            if (extRst)              state_d = ST_RESET;
            else if (wake_q & resumeRdy) begin
               state_d = resumeSt ? ST_SUB_RUN : ST_MAIN_RUN;
            end
         end
         ST_WATCH: begin
            if (extRst)              state_d = ST_RESET;
            else if (extIrqS | watchIrq) state_d = ST_SUB_RUN;
         end
         default:                    state_d = ST_RESET;
      endcase
   end

   // which run clock the core returns to after sleep or stop
   always_comb begin
      onSub_d = onSub_q;
      if (state_d == ST_SUB_RUN)       onSub_d = 1'b1;
      else if (state_d == ST_MAIN_RUN) onSub_d = 1'b0;
      else if (state_d == ST_RESET)    onSub_d = 1'b0;
   end

   // oscillator enables follow the state being entered
   wire mainOscEn_d = (state_d != ST_STOP) & (state_d != ST_WATCH)
                    & ~((state_d == ST_SUB_RUN) & ~clkSel_q & ~wrClk)
                    & ~((state_d == ST_SLEEP) & onSub_d);
   wire subOscEn_d  = DUAL_CLOCK & (state_d != ST_STOP);

   // ----------------------------------------------------------------
   // sequencer registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= ST_RESET;
         onSub_q <= 1'b0;
      end else begin
         state_q <= state_d;
         onSub_q <= onSub_d;
      end
   end

   // oscillator ready flags: the expiry pulse wins over the clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         mainRdy_q <= 1'b0;
         subRdy_q  <= 1'b0;
      end else begin
         mainRdy_q <= mainWaitDone | (mainRdy_q & mainOscEn_d);
         subRdy_q  <= subWaitDone  | (subRdy_q & subOscEn_d);
      end
   end

   // stop wake request, held until the oscillator is ready
   always_ff @(posedge mclk) begin
      if (rst) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= (state_q == ST_STOP) & (wake_q | extIrqS);
      end
   end

   // software reset stretch
   always_ff @(posedge mclk) begin
      if (rst) begin
         swCnt_q <= '0;
      end else if (reqSwRst & inRun) begin
         swCnt_q <= SW_RST_CW'(SW_RST_CYCLES);
      end else if (swRst) begin
         swCnt_q <= swCnt_q - 1'b1;
      end
   end

   // control bits written by software
   always_ff @(posedge mclk) begin
      if (rst | (state_d == ST_RESET)) begin
         clkSel_q <= CLK_SEL_RST;
         hiZ_q    <= STBY_HIZ_RST;
      end else begin
         if (wrClk & inRun) clkSel_q <= selNew;
         if (wrStby)        hiZ_q    <= wb_dat_i[STBY_HIZ_BIT];
      end
   end

   // ----------------------------------------------------------------
   // wishbone answer
   // ----------------------------------------------------------------
   wire [31:0] rdClk  = 32'(({~onSub_q, clkSel_q} & 2'b11));
   wire [31:0] rdStby = 32'({hiZ_q, 1'b1}) << STBY_SWRST_BIT;
   wire [31:0] rdStat = 32'(state_q);
   wire [31:0] rdMux  = selClk  ? rdClk
                      : selStby ? rdStby
                      : selStat ? rdStat
                      : 32'h0000_0000;

   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_q    <= 1'b0;
         rdData_q <= 32'h0000_0000;
      end else begin
         ack_q    <= busReq & ~ack_q;
         rdData_q <= rdMux;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdData_q;

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         sysReset  <= 1'b1;
         cpuRun    <= 1'b0;
         sysClkSub <= 1'b0;
         mainOscEn <= 1'b1;
         subOscEn  <= DUAL_CLOCK;
         pinHiZ    <= 1'b0;
         stateCode <= 3'h0;
      end else begin
         sysReset  <= (state_d == ST_RESET);
         cpuRun    <= (state_d == ST_MAIN_RUN) | (state_d == ST_SUB_RUN);
         sysClkSub <= onSub_d;
         mainOscEn <= mainOscEn_d;
         subOscEn  <= subOscEn_d;
         pinHiZ    <= hiZ_q & ((state_d == ST_STOP)
                              | (state_d == ST_WATCH));
         stateCode <= 3'(state_d);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence seqStopWake;
      (state_q == ST_STOP) && wake_q && !extRst;
   endsequence

   AST_POR_WAIT: assert property (
      ($past(state_q) == ST_RESET) && (state_q == ST_MAIN_RUN)
      |-> (!HAS_POR || $past(mainRdy_q)) && !$past(extRst))
      else $error("main run entered before wait or release");

   AST_RUN_RESET: assert property (
      (state_q == ST_MAIN_RUN) && (wdtReset || extRst)
      |=> (state_q == ST_RESET) && sysReset)
      else $error("reset source ignored in main run");

   AST_SUB_SWITCH: assert property (
      (state_q == ST_MAIN_RUN) && wrClk && !selNew && !runReset
      && !goStop && !goSleep |=> (state_q == ST_SUB_RUN) && sysClkSub)
      else $error("clock select 0 did not reach sub run");

   AST_MAIN_RETURN: assert property (
      ($past(state_q) == ST_SUB_RUN) && (state_q == ST_MAIN_RUN)
      |-> $past(mainRdy_q) && $past(clkSel_q))
      else $error("main run left sub before wait");

   AST_STANDBY_REFUSE: assert property (
      inRun && irqPending && !runReset |=> inRun || state_q == ST_MAIN_RUN)
      else $error("standby entered with interrupt pending");

   AST_STOP_FIRST: assert property (
      stbyOk && reqStop && !runReset |=> (state_q == ST_STOP))
      else $error("stop request lost priority");

   AST_STOP_WAKE: assert property (
      seqStopWake ##0 !resumeRdy |=> (state_q == ST_STOP))
      else $error("stop left before oscillator ready");

   AST_WATCH_GATE: assert property (
      (state_q == ST_WATCH) && ($past(state_q) != ST_WATCH)
      |-> $past(state_q) == ST_SUB_RUN && !$past(clkSel_q))
      else $error("watch entered from wrong state");

   AST_STANDBY_NO_SW: assert property (
      (state_q inside {ST_SLEEP, ST_STOP, ST_WATCH}) && !extRst
      |=> state_q != ST_RESET)
      else $error("standby reset without external reset");

   AST_SINGLE_CLOCK: assert property (
      !DUAL_CLOCK |-> state_q != ST_SUB_RUN && state_q != ST_WATCH)
      else $error("sub clock state in single clock build");

endmodule // pms_sequencer

// File: testbench.sv
// self-checking bench of the power mode sequencer, dual and single clock
// assumes a classic wishbone slave that acks one cycle after the request
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
         err_total++; \
      end \
   end

module testbench;
   import pms_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        mclk;
   logic        rst;
   logic        wbCyc;
   logic        wbStb;
   logic        wbWe;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatW;
   logic [31:0] wbDatR;
   logic        wbAck;
   logic        extResetN;
   logic        extIrq;
   logic        irqPending;
   logic        watchIrq;
   logic        wdtReset;
   logic        mainWaitDone;
   logic        subWaitDone;
   logic        sysReset;
   logic        cpuRun;
   logic        sysClkSub;
   logic        pinHiZ;
   logic [2:0]  stateCode;
   logic [2:0]  stateCode2;
   logic [2:0]  stateCode3;
   logic        mainOscEn;
   logic        subOscEn;
   int          err_total;
   int          checks;
   int          cycCnt;

   // ----------------------------------------------------------------
   // designs: dual clock, single clock, no power-on reset
   // ----------------------------------------------------------------
   pms_sequencer DUT (
      .mclk(mclk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
      .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
      .extResetN(extResetN), .extIrq(extIrq), .irqPending(irqPending),
      .watchIrq(watchIrq), .wdtReset(wdtReset),
      .mainWaitDone(mainWaitDone), .subWaitDone(subWaitDone),
      .sysReset(sysReset), .cpuRun(cpuRun), .sysClkSub(sysClkSub),
      .mainOscEn(mainOscEn), .subOscEn(subOscEn), .pinHiZ(pinHiZ),
      .stateCode(stateCode));

   pms_sequencer #(.DUAL_CLOCK(1'b0)) DUT2 (
      .mclk(mclk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
      .wb_dat_i(wbDatW), .wb_dat_o(), .wb_ack_o(),
      .extResetN(extResetN), .extIrq(extIrq), .irqPending(irqPending),
      .watchIrq(watchIrq), .wdtReset(wdtReset),
      .mainWaitDone(mainWaitDone), .subWaitDone(subWaitDone),
      .sysReset(), .cpuRun(), .sysClkSub(), .mainOscEn(), .subOscEn(),
      .pinHiZ(), .stateCode(stateCode2));

   pms_sequencer #(.HAS_POR(1'b0)) DUT3 (
      .mclk(mclk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
      .wb_dat_i(wbDatW), .wb_dat_o(), .wb_ack_o(),
      .extResetN(extResetN), .extIrq(extIrq), .irqPending(irqPending),
      .watchIrq(watchIrq), .wdtReset(wdtReset),
      .mainWaitDone(mainWaitDone), .subWaitDone(subWaitDone),
      .sysReset(), .cpuRun(), .sysClkSub(), .mainOscEn(), .subOscEn(),
      .pinHiZ(), .stateCode(stateCode3));

   // ----------------------------------------------------------------
   // clock, timeout, tasks
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycCnt <= cycCnt + 1;
      if (cycCnt == 20000) begin
         err_total++;
         finish_test;
      end
   end

   task automatic finish_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one classic cycle, held until ack is sampled high
   task automatic xfer(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= a;
      wbSel  <= 4'hf;
      wbDatW <= d;
      do begin
         @(posedge mclk);
      end while (wbAck !== 1'b1);
      q = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0000_0000, q);
      `CHK(q, exp)
   endtask

   // waits a bounded time for a state, then compares
   task automatic wait_st(input logic [2:0] exp);
      int n;
      n = 0;
      while (stateCode !== exp && n < 40) begin
         @(posedge mclk);
         n++;
      end
      `CHK(stateCode, exp)
   endtask

   // one-cycle pulse: 0 main wait, 1 sub wait, 2 watch interrupt
   task automatic pulse(input int which);
      @(posedge mclk);
      case (which)
         0: mainWaitDone <= 1'b1;
         1: subWaitDone  <= 1'b1;
         default: watchIrq <= 1'b1;
      endcase
      @(posedge mclk);
      mainWaitDone <= 1'b0;
      subWaitDone  <= 1'b0;
      watchIrq     <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0;
      wbAdr = 8'h00; wbSel = 4'h0; wbDatW = 32'h0000_0000;
      extResetN = 1'b0; extIrq = 1'b0; irqPending = 1'b0;
      watchIrq = 1'b0; wdtReset = 1'b0; mainWaitDone = 1'b0;
      subWaitDone = 1'b0; err_total = 0; checks = 0; cycCnt = 0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      idle(5);
      `CHK(sysReset, 1'b1)
      `CHK(stateCode, 3'd0)
      pulse(0);
      idle(4);
      `CHK(stateCode, 3'd0)
      `CHK(stateCode3, 3'd0)
      extResetN <= 1'b1;
      wait_st(3'd1);
      `CHK(stateCode3, 3'd1)
      `CHK(cpuRun, 1'b1)
      `CHK(mainOscEn, 1'b1)
      rd(ADR_CLK_CTRL, 32'h0000_0003);
      rd(ADR_STBY_CTRL, 32'h0000_0010);
      rd(8'h0c, 32'h0000_0000);
      wr(ADR_STBY_CTRL, 32'h0000_0008);
      idle(4);
      `CHK(stateCode, 3'd1)
      irqPending <= 1'b1;
      wr(ADR_STBY_CTRL, 32'h0000_0040);
      idle(3);
      irqPending <= 1'b0;
      idle(4);
      `CHK(stateCode, 3'd1)
      wr(ADR_STBY_CTRL, 32'h0000_0040);
      wait_st(3'd3);
      `CHK(cpuRun, 1'b0)
      irqPending <= 1'b1;
      wait_st(3'd1);
      irqPending <= 1'b0;
      // stop with pins high impedance, stop, sleep and watch requests at once
      wr(ADR_STBY_CTRL, 32'h0000_0020);
      rd(ADR_STBY_CTRL, 32'h0000_0030);
      wr(ADR_STBY_CTRL, 32'h0000_00e8);
      wait_st(3'd4);
      `CHK(pinHiZ, 1'b1)
      `CHK(mainOscEn, 1'b0)
      `CHK(subOscEn, 1'b0)
      wdtReset <= 1'b1;
      idle(4);
      `CHK(stateCode, 3'd4)
      wdtReset <= 1'b0;
      extIrq <= 1'b1;
      idle(6);
      `CHK(stateCode, 3'd4)
      pulse(0);
      wait_st(3'd1);
      extIrq <= 1'b0;
      // sub clock, watch and sleep from sub
      wr(ADR_CLK_CTRL, 32'h0000_0000);
      wait_st(3'd2);
      `CHK(sysClkSub, 1'b1)
      `CHK(stateCode2, 3'd1)
      rd(ADR_CLK_CTRL, 32'h0000_0000);
      wr(ADR_STBY_CTRL, 32'h0000_0008);
      wait_st(3'd5);
      `CHK(mainOscEn, 1'b0)
      `CHK(subOscEn, 1'b1)
      pulse(2);
      wait_st(3'd2);
      wr(ADR_STBY_CTRL, 32'h0000_0040);
      wait_st(3'd3);
      irqPending <= 1'b1;
      wait_st(3'd2);
      irqPending <= 1'b0;
      wr(ADR_CLK_CTRL, 32'h0000_0001);
      idle(5);
      `CHK(stateCode, 3'd2)
      rd(ADR_CLK_CTRL, 32'h0000_0001);
      pulse(0);
      wait_st(3'd1);
      rd(ADR_CLK_CTRL, 32'h0000_0003);
      // reset sources in main run: watchdog, software, external
      for (int src = 0; src < 3; src++) begin
         if (src == 0) wdtReset <= 1'b1;
         else if (src == 1) wr(ADR_STBY_CTRL, 32'h0000_0010);
         else extResetN <= 1'b0;
         wait_st(3'd0);
         wdtReset  <= 1'b0;
         idle(8);
         pulse(0);
         extResetN <= 1'b1;
         wait_st(3'd1);
         `CHK(stateCode3, 3'd1)
         rd(ADR_CLK_CTRL, 32'h0000_0003);
      end
      // external reset releases sleep
      wr(ADR_STBY_CTRL, 32'h0000_0040);
      wait_st(3'd3);
      extResetN <= 1'b0;
      wait_st(3'd0);
      idle(8);
      pulse(0);
      extResetN <= 1'b1;
      wait_st(3'd1);
      // external reset releases stop, held past the oscillator wait
      wr(ADR_STBY_CTRL, 32'h0000_0080);
      wait_st(3'd4);
      extResetN <= 1'b0;
      wait_st(3'd0);
      pulse(0);
      extResetN <= 1'b1;
      wait_st(3'd1);
      `CHK(stateCode3, 3'd1)
      finish_test;
   end

endmodule // testbench
